// [rtl/eiq_front.sv]
/*
 * external request flags, sense selection, nonmaskable edge, internal
 * request gating and vector selection. assumes pins are asynchronous and
 * that the processor pulses ack with the vector it is taking.
 */
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "eiq_defs.svh"
module eiq_front (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// pins
	input  wire logic [5:0]  line_pin_n,
	input  wire logic        nmi_pin,
	// internal module flags and enables
	input  wire logic [3:0]  int_flag,
	input  wire logic [3:0]  int_en,
	input  wire logic [15:0] timer_req,
	// processor and transfer controller
	input  wire logic        ack,
	input  wire logic [6:0]  ack_vector,
	input  wire logic [5:0]  xfer_start,
	input  wire logic        xfer_irq_select,
	output logic      [6:0]  vector,
	output logic             vec_valid,
	output logic             nmi_req,
	output logic             wake
);
	logic [5:0] sync1_reg;
	logic       nsync1_reg;
	eiq_pkg::eiq_state_s s_reg, s_next;
	logic [5:0] ev;
	logic [5:0] ack_line;
	logic       nmi_ev;
	logic [5:0] line_req;
	logic [2:0] best_lvl;
	logic [6:0] best_vec;
	logic       found;
	logic [25:0] src_req;
	logic [6:0]  src_vec [26];
	logic [2:0]  src_lvl [26];
	logic [5:0]  set6;
	logic [7:0]  rd_mux;

	// first synchroniser stage, read only by the second
	always_ff @(posedge mclk) begin
		if (ce) begin
			sync1_reg  <= line_pin_n; // R14
			nsync1_reg <= nmi_pin;
		end
	end

	// sense detection per line
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			case (eiq_pkg::eiq_sense_e'(s_reg.sense[2*i +: 2])) // R11 R12
				eiq_pkg::EIQ_LOW:  ev[i] = ~s_reg.pin_q[i];
				eiq_pkg::EIQ_FALL: ev[i] = s_reg.pin_prev[i] & ~s_reg.pin_q[i];
				eiq_pkg::EIQ_RISE: ev[i] = ~s_reg.pin_prev[i] & s_reg.pin_q[i];
				eiq_pkg::EIQ_BOTH: ev[i] = s_reg.pin_prev[i] ^ s_reg.pin_q[i];
				default:           ev[i] = 1'b0;
			endcase
			ack_line[i] = ack && ack_vector == `EIQ_VEC_LINE0 + 7'(i);
		end
		nmi_ev = s_reg.nmi_edge ? (~s_reg.nmi_prev & s_reg.nmi_q)
		                        : (s_reg.nmi_prev & ~s_reg.nmi_q); // R10
	end

	// source table: lines, then internal modules, which all share the one prio_int level
	always_comb begin
		line_req = s_reg.flags & s_reg.enable; // R13
		for (int i = 0; i < 6; i++) begin
			src_req[i] = line_req[i];
			src_vec[i] = `EIQ_VEC_LINE0 + 7'(i); // R21
		end
		src_lvl[0] = s_reg.prio_l01;
		src_lvl[1] = s_reg.prio_l1;
		src_lvl[2] = s_reg.prio_l23; // R19
		src_lvl[3] = s_reg.prio_l23;
		src_lvl[4] = s_reg.prio_l45;
		src_lvl[5] = s_reg.prio_l45;
		src_req[6] = int_flag[0] & int_en[0]; // R15
		src_req[7] = int_flag[1] & int_en[1];
		src_req[8] = int_flag[2] & int_en[2];
		src_req[9] = int_flag[3] & int_en[3];
		src_vec[6] = `EIQ_VEC_XFER_END; // R22
		src_vec[7] = `EIQ_VEC_WDOG;
		src_vec[8] = `EIQ_VEC_BREAK;
		src_vec[9] = `EIQ_VEC_CONV;
		for (int i = 6; i < 10; i++)
			src_lvl[i] = s_reg.prio_int;
		for (int i = 0; i < 16; i++) begin
			src_req[10+i] = timer_req[i];
			src_vec[10+i] = `EIQ_VEC_TIMER0 + 7'(i);
			src_lvl[10+i] = s_reg.prio_int;
		end
	end

	// pick highest level; ties go to the lowest vector by scan order
	always_comb begin
		found    = 1'b0;
		best_lvl = 3'h0;
		best_vec = `EIQ_VEC_NONE;
		for (int i = 0; i < 26; i++) begin
			if (src_req[i] && (!found || src_lvl[i] > best_lvl)) begin // R17 R18
				found    = 1'b1;
				best_lvl = src_lvl[i];
				best_vec = src_vec[i];
			end
		end
	end

	// register read mux
	always_comb begin
		case (addr)
			`EIQ_OFS_FLAGS:   rd_mux = {2'b00, s_reg.flags}; // R1
			`EIQ_OFS_ENABLE:  rd_mux = {2'b00, s_reg.enable};
			`EIQ_OFS_SENSE_L: rd_mux = s_reg.sense[7:0];
			`EIQ_OFS_SENSE_H: rd_mux = s_reg.sense[15:8];
			`EIQ_OFS_SYSCTL:  rd_mux = {4'h0, s_reg.nmi_edge, 3'h0};
			`EIQ_OFS_PRIO_A:  rd_mux = {1'b0, s_reg.prio_l01, 1'b0, s_reg.prio_l1};
			`EIQ_OFS_PRIO_B:  rd_mux = {1'b0, s_reg.prio_l23, 1'b0, s_reg.prio_l45};
			`EIQ_OFS_PRIO_C:  rd_mux = {5'h00, s_reg.prio_int};
			`EIQ_OFS_VECTOR:  rd_mux = {s_reg.vec_valid, s_reg.vector};
			default:          rd_mux = 8'h00;
		endcase
	end

	// next state
	always_comb begin
		s_next = s_reg;
		s_next.pin_q    = sync1_reg;
		s_next.pin_prev = s_reg.pin_q;
		s_next.nmi_q    = nsync1_reg;
		s_next.nmi_prev = s_reg.nmi_q;
		set6 = ev;
		// clears first, then sets so a new event wins
		for (int i = 0; i < 6; i++) begin
			if (ack_line[i]) begin
				if (s_reg.sense[2*i +: 2] != 2'b00) // R5
					s_next.flags[i] = 1'b0;
				else if (s_reg.pin_q[i]) // R4
					s_next.flags[i] = 1'b0;
			end
			if (xfer_start[i] && !xfer_irq_select) // R6 R16
				s_next.flags[i] = 1'b0;
		end
		if (wr && addr == `EIQ_OFS_FLAGS)
			s_next.flags = s_next.flags & wdata[5:0]; // R7 R2
		s_next.flags = s_next.flags | set6; // R3
		if (wr) begin
			case (addr)
				`EIQ_OFS_ENABLE:  s_next.enable = wdata[5:0];
				`EIQ_OFS_SENSE_L: s_next.sense[7:0] = wdata;
				`EIQ_OFS_SENSE_H: s_next.sense[15:8] = wdata;
				`EIQ_OFS_SYSCTL:  s_next.nmi_edge = wdata[`EIQ_NMI_EDGE_BIT];
				`EIQ_OFS_PRIO_A: begin
					s_next.prio_l01 = wdata[6:4];
					s_next.prio_l1  = wdata[2:0];
				end
				`EIQ_OFS_PRIO_B: begin
					s_next.prio_l23 = wdata[6:4];
					s_next.prio_l45 = wdata[2:0];
				end
				`EIQ_OFS_PRIO_C:  s_next.prio_int = wdata[2:0];
				default: ;
			endcase
		end
		s_next.rdata = rd ? rd_mux : 8'h00;
		// nonmaskable request held until its vector is taken
		if (ack && ack_vector == `EIQ_VEC_NMI)
			s_next.nmi_req = 1'b0;
		if (nmi_ev)
			s_next.nmi_req = 1'b1;
		if (s_next.nmi_req) begin // R9
			s_next.vector    = `EIQ_VEC_NMI;
			s_next.vec_valid = 1'b1;
		end else begin
			s_next.vector    = best_vec; // R23
			s_next.vec_valid = found;
		end
		s_next.wake = nmi_ev | (|ev); // R8
	end

	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg          <= '0;
			s_reg.flags    <= 6'(`EIQ_FLAGS_RST);
			s_reg.enable   <= 6'(`EIQ_ENABLE_RST);
			s_reg.sense    <= `EIQ_SENSE_RST;
			s_reg.prio_l01 <= `EIQ_PRIO_RST; // R20
			s_reg.prio_l1  <= `EIQ_PRIO_RST;
			s_reg.prio_l23 <= `EIQ_PRIO_RST;
			s_reg.prio_l45 <= `EIQ_PRIO_RST;
			s_reg.prio_int <= `EIQ_PRIO_RST;
			s_reg.pin_q    <= 6'h3f;
			s_reg.pin_prev <= 6'h3f;
			s_reg.nmi_q    <= 1'b1;
			s_reg.nmi_prev <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign rdata     = s_reg.rdata;
	assign vector    = s_reg.vector;
	assign vec_valid = s_reg.vec_valid;
	assign nmi_req   = s_reg.nmi_req;
	assign wake      = s_reg.wake;

	// checks
	property p_flag_set;
		@(posedge mclk) disable iff (rst)
		(ce && ev[0]) |=> s_reg.flags[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("line0 event lost"); // R3
	property p_sw_clear;
		@(posedge mclk) disable iff (rst)
		(ce && wr && addr == `EIQ_OFS_FLAGS && !wdata[1] && !ev[1]) |=> !s_reg.flags[1];
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("flag1 not cleared"); // R7
	property p_edge_ack;
		@(posedge mclk) disable iff (rst)
		(ce && ack_line[2] && s_reg.sense[5:4] != 2'b00 && !ev[2]) |=> !s_reg.flags[2];
	endproperty
	a_edge_ack: assert property (p_edge_ack) else $error("flag2 kept"); // R5
	property p_level_ack;
		@(posedge mclk) disable iff (rst)
		(ce && ack_line[3] && s_reg.sense[7:6] == 2'b00 && !s_reg.pin_q[3])
			|=> s_reg.flags[3];
	endproperty
	a_level_ack: assert property (p_level_ack) else $error("level flag cleared"); // R4
	property p_xfer;
		@(posedge mclk) disable iff (rst)
		(ce && xfer_start[4] && !xfer_irq_select && !ev[4]) |=> !s_reg.flags[4];
	endproperty
	a_xfer: assert property (p_xfer) else $error("flag4 kept"); // R6
	property p_nmi_first;
		@(posedge mclk) disable iff (rst)
		nmi_req |-> vector == `EIQ_VEC_NMI;
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("nmi not first"); // R9
	property p_masked;
		@(posedge mclk) disable iff (rst)
		(ce && !nmi_req && s_reg.enable == 6'h00 && src_req[25:6] == '0)
			|=> !s_reg.vec_valid || s_reg.nmi_req;
	endproperty
	a_masked: assert property (p_masked) else $error("disabled line vectored"); // R13
	property p_rd_zero;
		@(posedge mclk) disable iff (rst)
		(ce && rd && addr == `EIQ_OFS_FLAGS) |=> rdata[7:6] == 2'b00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("reserved bits set"); // R1
	property p_wake;
		@(posedge mclk) disable iff (rst)
		(ce && nmi_ev) |=> wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // R8
	property p_wake_line;
		@(posedge mclk) disable iff (rst)
		(ce && |ev) |=> wake;
	endproperty
	a_wake_line: assert property (p_wake_line) else $error("no wake on line event"); // R8
	property p_nmi_rise;
		@(posedge mclk) disable iff (rst)
		(ce && s_reg.nmi_edge && !s_reg.nmi_prev && s_reg.nmi_q) |=> nmi_req;
	endproperty
	a_nmi_rise: assert property (p_nmi_rise) else $error("rising nmi lost"); // R10
	property p_nmi_fall;
		@(posedge mclk) disable iff (rst)
		(ce && !s_reg.nmi_edge && s_reg.nmi_prev && !s_reg.nmi_q) |=> nmi_req;
	endproperty
	a_nmi_fall: assert property (p_nmi_fall) else $error("falling nmi lost"); // R10
	property p_nmi_hold;
		@(posedge mclk) disable iff (rst)
		(ce && nmi_req && !(ack && ack_vector == `EIQ_VEC_NMI)) |=> nmi_req;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped untaken"); // R9
	property p_fall_set;
		@(posedge mclk) disable iff (rst)
		(ce && s_reg.sense[3:2] == 2'b01 && s_reg.pin_prev[1] && !s_reg.pin_q[1]) |=> s_reg.flags[1];
	endproperty
	a_fall_set: assert property (p_fall_set) else $error("line1 fall lost"); // R12
	property p_rise_set;
		@(posedge mclk) disable iff (rst)
		(ce && s_reg.sense[5:4] == 2'b10 && !s_reg.pin_prev[2] && s_reg.pin_q[2]) |=> s_reg.flags[2];
	endproperty
	a_rise_set: assert property (p_rise_set) else $error("line2 rise lost"); // R12
	property p_low_set;
		@(posedge mclk) disable iff (rst)
		(ce && s_reg.sense[11:10] == 2'b00 && !s_reg.pin_q[5]) |=> s_reg.flags[5];
	endproperty
	a_low_set: assert property (p_low_set) else $error("line5 low lost"); // R12
	property p_xfer_keep;
		@(posedge mclk) disable iff (rst)
		(ce && xfer_start[3] && xfer_irq_select && s_reg.flags[3] && !ack_line[3]
			&& !(wr && addr == `EIQ_OFS_FLAGS)) |=> s_reg.flags[3];
	endproperty
	a_xfer_keep: assert property (p_xfer_keep) else $error("flag3 cleared with select set"); // R6
	property p_vec_map;
		@(posedge mclk) disable iff (rst)
		(vec_valid && !nmi_req) |-> (vector >= 7'h10 && vector <= 7'h2f && vector != 7'h16
			&& vector != 7'h17 && vector != 7'h1a);
	endproperty
	a_vec_map: assert property (p_vec_map) else $error("vector outside table"); // R22
	property p_line_gate;
		@(posedge mclk) disable iff (rst)
		(ce && !s_reg.enable[0] && !s_reg.nmi_req && !nmi_ev)
			|=> vector != `EIQ_VEC_LINE0;
	endproperty
	a_line_gate: assert property (p_line_gate) else $error("disabled line0 vectored"); // R13
	property p_int_gate;
		@(posedge mclk) disable iff (rst)
		(ce && !int_en[0] && !s_reg.nmi_req && !nmi_ev)
			|=> vector != `EIQ_VEC_XFER_END;
	endproperty
	a_int_gate: assert property (p_int_gate) else $error("disabled source vectored"); // R15
	property p_top_line;
		@(posedge mclk) disable iff (rst)
		(ce && !s_reg.nmi_req && !nmi_ev && line_req[0] && s_reg.prio_l01 == 3'h7)
			|=> vec_valid && vector == `EIQ_VEC_LINE0;
	endproperty
	a_top_line: assert property (p_top_line) else $error("line0 not ranked first"); // R18
	property p_reset_vals;
		@(posedge mclk)
		rst |=> s_reg.flags == 6'h00 && s_reg.enable == 6'h00 && s_reg.prio_int == `EIQ_PRIO_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R20
	c_nmi:   cover property (@(posedge mclk) nmi_req);
	c_line:  cover property (@(posedge mclk) vec_valid && vector == `EIQ_VEC_LINE0);
	c_timer: cover property (@(posedge mclk) vec_valid && vector == `EIQ_VEC_TIMER0);
	c_int:   cover property (@(posedge mclk) vec_valid && vector == `EIQ_VEC_XFER_END);
	c_wake:  cover property (@(posedge mclk) wake);
endmodule

// [rtl/eiq_defs.svh]
/*
 * register offsets, field positions, reset values and vector numbers of the
 * external request front end. assumes it is included once per compile unit.
 */
// What this block does
// [R1] eight-bit flag register, bits 5..0 are line request flags, reset zero.
// [R2] software writes only zeros to flag register bits 7 and 6.
// [R3] a line flag sets when its selected sense event occurs.
// [R4] low-level mode: flag clears on handling while pin is high.
// [R5] edge modes: flag clears when that line's handling runs.
// [R6] flag clears when line starts transfer controller with select bit zero.
// [R7] writing zero to a flag clears it.
// [R8] nonmaskable and six lines can wake the device from standby.
// [R9] nonmaskable request ranks highest and ignores all masking.
// [R10] a control bit picks rising or falling edge for the nonmaskable pin.
// [R11] each line senses low level, falling, rising or both edges.
// [R12] sense codes 00 low, 01 fall, 10 rise, 11 both; reset 00.
// [R13] each line has an enable bit, reset zero, gating its request.
// [R14] detection works whatever the pin direction.
// [R15] internal source requests only when its flag and enable are both one.
// [R16] transfer start ignores control mode and processor mask.
// [R17] default ranking: lower vector number wins.
// [R18] equal programmed levels fall back to default order.
// [R19] three-bit level per module; line pairs 2/3 and 4/5 share a field. internal modules and timers all share one field, prio_int, instead.
// [R20] level 000 lowest to 111 highest; fields reset to 111.
// [R21] vector address is four times vector; nonmaskable 7, lines 16..21.
// [R22] internal vectors 24, 25, 27, 28 and timers 32..47.
// [R23] present highest pending enabled vector; keep others pending.
`ifndef EIQ_DEFS_SVH
`define EIQ_DEFS_SVH
`define EIQ_OFS_FLAGS     4'h0
`define EIQ_OFS_ENABLE    4'h1
`define EIQ_OFS_SENSE_L   4'h2
`define EIQ_OFS_SENSE_H   4'h3
`define EIQ_OFS_SYSCTL    4'h4
`define EIQ_OFS_PRIO_A    4'h5
`define EIQ_OFS_PRIO_B    4'h6
`define EIQ_OFS_PRIO_C    4'h7
`define EIQ_OFS_PRIO_D    4'h8
`define EIQ_OFS_PRIO_E    4'h9
`define EIQ_OFS_VECTOR    4'ha
`define EIQ_FLAGS_RST     8'h00
`define EIQ_ENABLE_RST    8'h00
`define EIQ_SENSE_RST     16'h0000
`define EIQ_PRIO_RST      3'h7
`define EIQ_NMI_EDGE_BIT  3
`define EIQ_VEC_NMI       7'h07
`define EIQ_VEC_LINE0     7'h10
`define EIQ_VEC_XFER_END  7'h18
`define EIQ_VEC_WDOG      7'h19
`define EIQ_VEC_BREAK     7'h1b
`define EIQ_VEC_CONV      7'h1c
`define EIQ_VEC_TIMER0    7'h20
`define EIQ_VEC_NONE      7'h00
`endif

// [rtl/eiq_pkg.sv]
/*
 * types of the external request front end. assumes eiq_defs.svh alongside.
 */
package eiq_pkg;
	typedef enum logic [1:0] {
		EIQ_LOW,
		EIQ_FALL,
		EIQ_RISE,
		EIQ_BOTH
	} eiq_sense_e;

	typedef struct packed {
		logic [5:0]  flags;
		logic [5:0]  enable;
		logic [15:0] sense;
		logic        nmi_edge;
		logic [2:0]  prio_l01;
		logic [2:0]  prio_l1;
		logic [2:0]  prio_l23;
		logic [2:0]  prio_l45;
		logic [2:0]  prio_int;
		logic [7:0]  rdata;
		logic [6:0]  vector;
		logic        vec_valid;
		logic        nmi_req;
		logic        wake;
		logic [5:0]  pin_q;
		logic [5:0]  pin_prev;
		logic        nmi_q;
		logic        nmi_prev;
	} eiq_state_s;
endpackage

// [testbench/eiq_cpu_model.sv]
/*
 * processor and transfer controller model facing the request front end.
 * assumes the front end's clock and its synchronous active-high reset.
 */
`timescale 1ns/100ps
module eiq_cpu_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// bench control
	input  wire logic       go,
	input  wire logic [1:0] lag,
	input  wire logic       xfer_go,
	input  wire logic       xfer_sel,
	// front end
	input  wire logic [6:0] vector,
	input  wire logic       vec_valid,
	input  wire logic       nmi_req,
	output logic            ack,
	output logic      [6:0] ack_vector,
	output logic      [5:0] xfer_start,
	output logic            xfer_irq_select
);
	int hold = 0;
	// quiet values at time zero
	initial begin
		{ack, ack_vector, xfer_start, xfer_irq_select} = '0;
	end
	// nonmaskable first, then any valid vector; back off while the flags settle
	always @(posedge mclk) begin
		ack <= 1'b0;
		ack_vector <= ~ack_vector; // idle bus keeps moving
		if (hold > 0) begin
			hold--;
		end else if (go && !rst && (nmi_req || vec_valid)) begin
			ack <= 1'b1;
			ack_vector <= nmi_req ? 7'h07 : vector;
			hold = 5 + lag;
		end
	end
	// transfer start on line 3, whatever the mode and mask
	always @(posedge mclk) begin
		xfer_start <= {2'b00, xfer_go && !rst, 3'b000};
		xfer_irq_select <= xfer_go ? xfer_sel : ~xfer_irq_select;
	end
endmodule

// [testbench/external_irq_flags_and_vectors_tb_top.sv]
/*
 * self-checking bench of the request front end against a queue model.
 * assumes eiq_front and eiq_cpu_model compiled alongside.
 */
`timescale 1ns/100ps
`include "eiq_defs.svh"
module external_irq_flags_and_vectors_tb_top;
	logic        mclk, rst, ce, wr, rd, nmi_pin, ack, vec_valid, nmi_req, wake;
	logic        go, xfer_go, xfer_sel, xfer_irq_select;
	logic [3:0]  addr, int_flag, int_en;
	logic [7:0]  wdata, rdata;
	logic [5:0]  line_pin_n, xfer_start, en;
	logic [15:0] timer_req;
	logic [6:0]  vector, ack_vector;
	logic [6:0]  got_q [$];
	logic [6:0]  ivec [4] = '{`EIQ_VEC_XFER_END, `EIQ_VEC_WDOG, `EIQ_VEC_BREAK, `EIQ_VEC_CONV};
	logic [2:0]  lv [5];
	logic [1:0]  lag;
	logic [31:0] r;
	bit   [31:0] seed = 32'h0000_160e;
	int          errors, samples_checked, wake_cnt, ln;
	int          exp_q [$];
	eiq_front u_eiq_front (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .line_pin_n(line_pin_n), .nmi_pin(nmi_pin),
		.int_flag(int_flag), .int_en(int_en), .timer_req(timer_req), .ack(ack),
		.ack_vector(ack_vector), .xfer_start(xfer_start), .xfer_irq_select(xfer_irq_select),
		.vector(vector), .vec_valid(vec_valid), .nmi_req(nmi_req), .wake(wake));
	eiq_cpu_model u_eiq_cpu_model (.mclk(mclk), .rst(rst), .go(go), .lag(lag),
		.xfer_go(xfer_go), .xfer_sel(xfer_sel), .vector(vector), .vec_valid(vec_valid),
		.nmi_req(nmi_req), .ack(ack), .ack_vector(ack_vector), .xfer_start(xfer_start),
		.xfer_irq_select(xfer_irq_select));
	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// record taken vectors and retire the internal source behind each
	always @(posedge mclk) begin
		if (wake) wake_cnt++;
		if (ack) begin
			got_q.push_back(ack_vector);
			if (ack_vector >= 7'h20) timer_req[ack_vector - 7'h20] <= 1'b0;
			for (int i = 0; i < 4; i++) if (ack_vector == ivec[i]) int_flag[i] <= 1'b0;
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge mclk);
		{addr, rd} <= {a, 1'b1};
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic pins(input logic v, input logic [5:0] m);
		@(posedge mclk);
		line_pin_n <= v ? line_pin_n | m : line_pin_n & ~m;
		nmi_pin <= v;
		cyc(5);
	endtask
	task automatic take(input int n);
		got_q.delete();
		@(posedge mclk);
		go <= 1'b1;
		for (int t = 0; t < 600 && got_q.size() < n; t++) @(posedge mclk);
		go <= 1'b0;
		cyc(10);
		chk(8'(got_q.size()), 8'(n));
		if (got_q.size() != n) close_out();
	endtask
	// stimulus and comparison
	initial begin
		{ce, rst, wr, rd, go, xfer_go, xfer_sel, nmi_pin} = 8'hc1;
		{addr, wdata, int_flag, int_en, timer_req, lag} = '0;
		line_pin_n = 6'h3f;
		cyc(2);
		rst <= 1'b0;
		rd_reg(`EIQ_OFS_FLAGS, 8'h3f, 8'h00);
		rd_reg(`EIQ_OFS_PRIO_A, 8'h77, 8'h77);
		wr_reg(4'hb, 8'hff);
		rd_reg(4'hb, 8'hff, 8'h00);
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		wr_reg(`EIQ_OFS_ENABLE, 8'h3f);
		ce <= 1'b1;
		rd_reg(`EIQ_OFS_ENABLE, 8'h3f, 8'h00);
		// every sense code on a random line, nonmaskable edge alternating
		for (int m = 0; m < 4; m++) begin
			r = xs();
			ln = r % 6;
			wr_reg(`EIQ_OFS_SYSCTL, m[0] ? 8'h08 : 8'h00);
			wr_reg(ln < 4 ? `EIQ_OFS_SENSE_L : `EIQ_OFS_SENSE_H, 8'(m << 2 * (ln % 4)));
			wr_reg(`EIQ_OFS_FLAGS, 8'h00);
			pins(1'b0, 6'(1 << ln));
			rd_reg(`EIQ_OFS_FLAGS, 8'h3f, 8'(m != 2) << ln);
			chk(8'(nmi_req), m[0] ? 8'h00 : 8'h01);
			wr_reg(`EIQ_OFS_FLAGS, 8'h00);
			rd_reg(`EIQ_OFS_FLAGS, 8'h3f, 8'(m == 0) << ln);
			pins(1'b1, 6'(1 << ln));
			rd_reg(`EIQ_OFS_FLAGS, 8'h3f, 8'(m != 1) << ln);
			take(1);
			chk({1'b0, got_q[0]}, 8'h07);
			chk(8'(nmi_req), 8'h00);
		end
		// random enables, codes and levels; order of acceptance against the model
		repeat (4) begin
			r = xs();
			en = r[5:0];
			for (int i = 0; i < 5; i++) lv[i] = r[8 + 3 * i +: 3];
			r = xs();
			{int_flag, int_en, timer_req, lag} <= {4'hf, r[3:0], r[21:18], r[15:4], r[17:16]};
			wr_reg(`EIQ_OFS_ENABLE, {2'b00, en});
			wr_reg(`EIQ_OFS_SENSE_L, r[31:24]);
			wr_reg(`EIQ_OFS_SENSE_H, {4'h0, r[21:18]});
			wr_reg(`EIQ_OFS_PRIO_A, {1'b0, lv[0], 1'b0, lv[1]});
			wr_reg(`EIQ_OFS_PRIO_B, {1'b0, lv[2], 1'b0, lv[3]});
			wr_reg(`EIQ_OFS_PRIO_C, {5'h00, lv[4]});
			rd_reg(`EIQ_OFS_PRIO_B, 8'h77, {1'b0, lv[2], 1'b0, lv[3]});
			wr_reg(`EIQ_OFS_FLAGS, 8'h00);
			pins(1'b0, 6'h3f);
			pins(1'b1, 6'h3f);
			exp_q = '{7};
			for (int i = 0; i < 6; i++) if (en[i]) exp_q.push_back((7 - lv[i < 2 ? i : i / 2 + 1]) * 128 + 16 + i);
			for (int i = 0; i < 4; i++) if (int_en[i]) exp_q.push_back((7 - lv[4]) * 128 + ivec[i]);
			for (int i = 0; i < 16; i++) if (timer_req[i]) exp_q.push_back((7 - lv[4]) * 128 + 32 + i);
			exp_q.sort();
			take(exp_q.size());
			foreach (exp_q[k]) chk({1'b0, got_q[k]}, 8'(exp_q[k] % 128));
			rd_reg(`EIQ_OFS_FLAGS, 8'h3f, {2'b00, ~en});
			chk(8'(vec_valid), 8'h00);
		end
		// transfer start clears line 3 only with the select bit zero
		wr_reg(`EIQ_OFS_ENABLE, 8'h00);
		wr_reg(`EIQ_OFS_SENSE_L, 8'h40);
		wr_reg(`EIQ_OFS_FLAGS, 8'h00);
		pins(1'b0, 6'h08);
		for (int s = 1; s >= 0; s--) begin
			{xfer_sel, xfer_go} <= {s[0], 1'b1};
			@(posedge mclk);
			xfer_go <= 1'b0;
			rd_reg(`EIQ_OFS_FLAGS, 8'h3f, s ? 8'h08 : 8'h00);
		end
		chk(8'(wake_cnt > 0), 8'h01);
		close_out();
	end
endmodule
